// ===== shared/sadc_pkg.sv
// constants, carrier types and state codes for the scan-driven converter
// front end; assumes an apb master on pclk and a tap controller on tck.
// What this block does
// - precharge control low precharges the comparator latch
// - switch-cap test routes x10 stage to pin
// - supply-reference select makes supply the reference
// - enabling converter runs ten-decision dummy conversion first
// - hold low samples, hold high holds
// - converter power-on high powers converter, idles low

package sadc_pkg;

	// ==========================================================
	// converter control word, most significant chain bit first
	typedef struct packed {
		logic bandgap_neg_en;
		logic converter_power_on;
		logic amplifier_power_on;
		logic [9:0] dac_code;
		logic extch_bypass;
		logic gain_x10;
		logic gain_x20;
		logic ground_neg_en;
		logic hold;
		logic bandgap_aref_en;
		logic [7:0] input_mux_select;
		logic [2:0] negative_mux_select;
		logic gain_passgate_enable;
		logic comparator_precharge_n;
		logic switchcap_test_enable;
		logic settle_assist;
		logic supply_reference_select;
	} sadc_ctrl_s;

	// ==========================================================
	// conversion sequencer states
	typedef enum logic [2:0] {
		SEQ_OFF = 3'b000,
		SEQ_SAMPLE = 3'b001,
		SEQ_PRE = 3'b010,
		SEQ_EVAL = 3'b011,
		SEQ_IDLE = 3'b100
	} sadc_seq_e;

	// ==========================================================
	// sizes and counts
	localparam int CTRL_W = 35;
	localparam int CHAIN_LEN = 36;
	localparam logic [9:0] DAC_MID = 10'h200;
	localparam logic [3:0] DECISIONS = 4'hA;
	localparam logic [3:0] SAMPLE_CYCLES = 4'h4;
	// covers the output register, one cycle of comparator response and
	// the two-flop synchroniser; any fewer and a decision reads the
	// previous trial's comparator level
	localparam logic [3:0] EVAL_CYCLES = 4'h4;

	// ==========================================================
	// register map
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_RESULT = 12'h008;
	localparam int CTRL_EN = 0;
	localparam int CTRL_START = 1;
	localparam int CTRL_CH_LSB = 4;
	localparam int STAT_BUSY = 0;
	localparam int STAT_VALID = 1;
	localparam int STAT_SCAN = 2;
	localparam int STAT_COMP = 3;

	// ==========================================================
	// control word after reset: converter idle values
	localparam sadc_ctrl_s IDLE_WORD = '{
		bandgap_neg_en: 1'b0,
		converter_power_on: 1'b0,
		amplifier_power_on: 1'b0,
		dac_code: 10'h200,
		extch_bypass: 1'b1,
		gain_x10: 1'b0,
		gain_x20: 1'b0,
		ground_neg_en: 1'b0,
		hold: 1'b1,
		bandgap_aref_en: 1'b0,
		input_mux_select: 8'h01,
		negative_mux_select: 3'h0,
		gain_passgate_enable: 1'b1,
		comparator_precharge_n: 1'b1,
		switchcap_test_enable: 1'b0,
		settle_assist: 1'b0,
		supply_reference_select: 1'b0
	};

endpackage

// ===== rtl/sadc_scan_link.sv
// converter segment of the boundary-scan data register, on the test clock.
// assumes capture, shift and update strobes come from a tap on tck.
`timescale 1ns/1ns
`default_nettype none

module sadc_scan_link (
	// test link
	input wire logic tck,
	input wire logic presetn,
	input wire logic tdi,
	input wire logic capture_dr,
	input wire logic shift_dr,
	input wire logic update_dr,
	output logic tdo,
	// comparator observe pin
	input wire logic comp_pin,
	// towards the system clock domain
	output sadc_pkg::sadc_ctrl_s upd_word,
	output logic upd_toggle
);

	typedef struct packed {
		logic [sadc_pkg::CHAIN_LEN-1:0] shift;
		sadc_pkg::sadc_ctrl_s upd;
		logic tog;
		logic comp_s1;
		logic comp_s2;
	} sadc_link_s;

	localparam sadc_link_s LINK_RST = '{
		upd: sadc_pkg::IDLE_WORD,
		default: '0
	};

	sadc_link_s r_r;
	sadc_link_s r_nxt;

	// ==========================================================
	// capture, shift and update
	always_comb begin
		r_nxt = r_r;
		r_nxt.comp_s1 = comp_pin;
		r_nxt.comp_s2 = r_r.comp_s1;
		if (capture_dr) begin
			r_nxt.shift = {r_r.comp_s2, r_r.upd};
		end else if (shift_dr) begin
			r_nxt.shift = {tdi, r_r.shift[sadc_pkg::CHAIN_LEN-1:1]};
		end
		// the word stays still until the next update, so the toggle
		// alone is enough for the system side to take it safely
		if (update_dr) begin
			r_nxt.upd = r_r.shift[sadc_pkg::CTRL_W-1:0];
			r_nxt.tog = ~r_r.tog;
		end
	end

	always_ff @(posedge tck or negedge presetn) begin
		if (!presetn) begin
			r_r <= LINK_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign tdo = r_r.shift[0];
	assign upd_word = r_r.upd;
	assign upd_toggle = r_r.tog;

endmodule

`default_nettype wire

// ===== rtl/sadc_top.sv
// converter front end: apb registers, normal-mode sequencer and the
// selection between scan-driven and functional control of the converter.
// assumes pclk and tck are unrelated; all link traffic crosses by sync.
`timescale 1ns/1ns
`default_nettype none

module sadc_top (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// test link
	input wire logic tck,
	input wire logic tdi,
	input wire logic capture_dr,
	input wire logic shift_dr,
	input wire logic update_dr,
	input wire logic extest_active,
	output logic tdo,
	// converter
	input wire logic comp_pin,
	output sadc_pkg::sadc_ctrl_s adc_ctrl,
	output logic x10_to_pin4,
	output logic ref_supply_sel
);

	typedef struct packed {
		sadc_pkg::sadc_seq_e seq;
		logic [3:0] cnt;
		logic [3:0] dec;
		logic [9:0] code;
		logic dummy;
		logic valid;
		logic [9:0] result;
		logic en;
		logic en_q;
		logic [2:0] chan;
		logic start;
		logic scan_s1;
		logic scan_s2;
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic comp_s1;
		logic comp_s2;
		sadc_pkg::sadc_ctrl_s word;
		sadc_pkg::sadc_ctrl_s out;
		logic [31:0] prdata;
	} sadc_top_s;

	localparam sadc_top_s TOP_RST = '{
		seq: sadc_pkg::SEQ_OFF,
		word: sadc_pkg::IDLE_WORD,
		out: sadc_pkg::IDLE_WORD,
		default: '0
	};

	sadc_top_s r_r;
	sadc_top_s r_nxt;
	sadc_pkg::sadc_ctrl_s link_word;
	sadc_pkg::sadc_ctrl_s func;
	logic link_tog;
	logic wr_acc;

	// ==========================================================
	// successive approximation helpers
	function automatic logic [9:0] trial_bit(input logic [3:0] d);
		trial_bit = sadc_pkg::DAC_MID >> d;
	endfunction

	// comparator high means the dac lies above the input
	function automatic logic [9:0] sar_next(input logic [9:0] code,
		input logic [3:0] d, input logic comp);
		logic [9:0] c;
		c = code;
		if (comp) begin
			c = c & ~trial_bit(d);
		end
		if (d != sadc_pkg::DECISIONS - 4'h1) begin
			c = c | trial_bit(d + 4'h1);
		end
		sar_next = c;
	endfunction

	// ==========================================================
	// scan segment on the test clock
	sadc_scan_link u_link (
		.tck(tck),
		.presetn(presetn),
		.tdi(tdi),
		.capture_dr(capture_dr),
		.shift_dr(shift_dr),
		.update_dr(update_dr),
		.tdo(tdo),
		.comp_pin(comp_pin),
		.upd_word(link_word),
		.upd_toggle(link_tog)
	);

	assign wr_acc = psel && penable && pwrite;

	// ==========================================================
	// next state
	always_comb begin
		r_nxt = r_r;
		func = sadc_pkg::IDLE_WORD;
		r_nxt.scan_s1 = extest_active;
		r_nxt.scan_s2 = r_r.scan_s1;
		r_nxt.tog_s1 = link_tog;
		r_nxt.tog_s2 = r_r.tog_s1;
		r_nxt.tog_s3 = r_r.tog_s2;
		r_nxt.comp_s1 = comp_pin;
		r_nxt.comp_s2 = r_r.comp_s1;
		r_nxt.en_q = r_r.en;
		if (r_r.tog_s2 != r_r.tog_s3) begin
			r_nxt.word = link_word;
		end

		// read data is loaded in the setup cycle for a zero-wait answer
		if (psel && !penable) begin
			r_nxt.prdata = '0;
			case (paddr)
				sadc_pkg::OFF_CTRL: begin
					r_nxt.prdata[sadc_pkg::CTRL_EN] = r_r.en;
					r_nxt.prdata[sadc_pkg::CTRL_CH_LSB +: 3] = r_r.chan;
				end
				sadc_pkg::OFF_STATUS: begin
					r_nxt.prdata[sadc_pkg::STAT_BUSY] =
						(r_r.seq != sadc_pkg::SEQ_OFF) &&
						(r_r.seq != sadc_pkg::SEQ_IDLE);
					r_nxt.prdata[sadc_pkg::STAT_VALID] = r_r.valid;
					r_nxt.prdata[sadc_pkg::STAT_SCAN] = r_r.scan_s2;
					r_nxt.prdata[sadc_pkg::STAT_COMP] = r_r.comp_s2;
				end
				sadc_pkg::OFF_RESULT: begin
					r_nxt.prdata[9:0] = r_r.result;
				end
				default: begin
					r_nxt.prdata = '0;
				end
			endcase
		end

		// normal-mode sequencer; it keeps running under scan, only its
		// outputs are set aside while the scan word owns the converter
		func.converter_power_on = r_r.en;
		func.input_mux_select = 8'h01 << r_r.chan;
		func.extch_bypass = 1'b1;
		case (r_r.seq)
			sadc_pkg::SEQ_OFF: begin
				r_nxt.valid = 1'b0;
				if (r_r.en && !r_r.en_q) begin
					r_nxt.dummy = 1'b1;
					r_nxt.seq = sadc_pkg::SEQ_SAMPLE;
					r_nxt.cnt = 4'h0;
				end
			end
			sadc_pkg::SEQ_SAMPLE: begin
				func.hold = 1'b0;
				func.dac_code = sadc_pkg::DAC_MID;
				r_nxt.cnt = r_r.cnt + 4'h1;
				if (r_r.cnt == sadc_pkg::SAMPLE_CYCLES - 4'h1) begin
					r_nxt.seq = sadc_pkg::SEQ_PRE;
					r_nxt.dec = 4'h0;
					r_nxt.code = sadc_pkg::DAC_MID;
				end
			end
			sadc_pkg::SEQ_PRE: begin
				func.comparator_precharge_n = 1'b0;
				func.dac_code = r_r.code;
				r_nxt.seq = sadc_pkg::SEQ_EVAL;
				r_nxt.cnt = 4'h0;
			end
			sadc_pkg::SEQ_EVAL: begin
				func.dac_code = r_r.code;
				r_nxt.cnt = r_r.cnt + 4'h1;
				if (r_r.cnt == sadc_pkg::EVAL_CYCLES - 4'h1) begin
					r_nxt.code = sar_next(r_r.code, r_r.dec, r_r.comp_s2);
					r_nxt.dec = r_r.dec + 4'h1;
					r_nxt.seq = sadc_pkg::SEQ_PRE;
					// ten decisions end a conversion
					if (r_r.dec == sadc_pkg::DECISIONS - 4'h1) begin
						r_nxt.seq = sadc_pkg::SEQ_IDLE;
						r_nxt.valid = 1'b1;
						r_nxt.dummy = 1'b0;
						if (!r_r.dummy) begin
							r_nxt.result = sar_next(r_r.code, r_r.dec,
								r_r.comp_s2);
						end
					end
				end
			end
			sadc_pkg::SEQ_IDLE: begin
				if (r_r.start) begin
					r_nxt.start = 1'b0;
					r_nxt.seq = sadc_pkg::SEQ_SAMPLE;
					r_nxt.cnt = 4'h0;
				end
			end
			default: begin
				r_nxt.seq = sadc_pkg::SEQ_OFF;
			end
		endcase

		// register writes after the sequencer so a start written while enabled is never lost
		if (wr_acc && paddr == sadc_pkg::OFF_CTRL) begin
			r_nxt.en = pwdata[sadc_pkg::CTRL_EN];
			r_nxt.chan = pwdata[sadc_pkg::CTRL_CH_LSB +: 3];
			if (pwdata[sadc_pkg::CTRL_START]) begin
				r_nxt.start = 1'b1;
			end
		end
		if (!r_r.en) begin
			r_nxt.seq = sadc_pkg::SEQ_OFF;
			r_nxt.valid = 1'b0;
			r_nxt.start = 1'b0;
		end

		r_nxt.out = r_r.scan_s2 ? r_r.word : func;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r <= TOP_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign prdata = r_r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr != sadc_pkg::OFF_CTRL) &&
		(paddr != sadc_pkg::OFF_STATUS) && (paddr != sadc_pkg::OFF_RESULT);
	assign adc_ctrl = r_r.out;
	assign x10_to_pin4 = r_r.out.switchcap_test_enable;
	assign ref_supply_sel = r_r.out.supply_reference_select;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_comparator_precharge_n_low: assert property (
		(!r_r.scan_s2 && r_r.seq == sadc_pkg::SEQ_PRE) |=>
		!adc_ctrl.comparator_precharge_n && adc_ctrl.hold)
		else $error("precharge not driven low in precharge phase");
	a_comparator_precharge_n_release: assert property (
		(!r_r.scan_s2 && r_r.seq == sadc_pkg::SEQ_EVAL) |=>
		adc_ctrl.comparator_precharge_n)
		else $error("precharge left low while evaluating");
	a_x10_route: assert property (
		(r_r.scan_s2 && r_r.word.switchcap_test_enable) |=> x10_to_pin4)
		else $error("switch-cap test did not route x10 stage");
	a_supply_ref: assert property (
		(r_r.scan_s2 && r_r.word.supply_reference_select) |=>
		ref_supply_sel)
		else $error("supply reference not selected");
	a_dummy_ten: assert property (
		(r_r.en && r_r.seq == sadc_pkg::SEQ_EVAL && r_r.dummy &&
		r_r.cnt == sadc_pkg::EVAL_CYCLES - 4'h1 &&
		r_r.dec == sadc_pkg::DECISIONS - 4'h1) |=>
		r_r.valid && r_r.seq == sadc_pkg::SEQ_IDLE && !r_r.dummy)
		else $error("dummy conversion did not end after ten decisions");
	a_valid_after_dummy: assert property (
		$rose(r_r.valid) |-> $past(r_r.dummy) && $past(r_r.dec) == 4'h9)
		else $error("results valid without a dummy conversion");
	a_sample_mid: assert property (
		(!r_r.scan_s2 && r_r.seq == sadc_pkg::SEQ_SAMPLE) |=>
		!adc_ctrl.hold && adc_ctrl.dac_code == sadc_pkg::DAC_MID)
		else $error("sampling without hold low at dac midpoint");
	a_power_follows: assert property (
		(!r_r.scan_s2 && !r_r.en) |=> !adc_ctrl.converter_power_on)
		else $error("converter powered while disabled");

	c_dummy_done: cover property ($rose(r_r.valid));
	c_scan_word: cover property (r_r.scan_s2 && r_r.tog_s2 != r_r.tog_s3);
	c_conversion: cover property (
		r_r.seq == sadc_pkg::SEQ_EVAL && !r_r.dummy ##1
		r_r.seq == sadc_pkg::SEQ_IDLE);

endmodule

`default_nettype wire

// ===== tb/sadc_tester.sv
// model of the external scan test controller on the link clock.
// assumes the converter segment is the only stage between tdi and tdo.
`timescale 1ns/1ns
`default_nettype none

module sadc_tester (
	// test link
	output logic tck,
	output logic tdi,
	output logic capture_dr,
	output logic shift_dr,
	output logic update_dr,
	output logic extest_active,
	input wire logic tdo
);
	// ==========================================================
	// link clock, phase unrelated to pclk
	initial begin
		tck = 1'b0;
		tdi = 1'b0;
		capture_dr = 1'b0;
		shift_dr = 1'b0;
		update_dr = 1'b0;
		extest_active = 1'b0;
		#37;
		forever #80 tck = ~tck;
	end

	task automatic set_extest(input logic v);
		@(posedge tck) extest_active <= v;
	endtask

	// ==========================================================
	// capture, 36 shifts, update; spare edges let the comparator settle
	task automatic frame(input sadc_pkg::sadc_ctrl_s w,
		output logic [35:0] q);
		logic [35:0] d;
		// zero fill pads the comparator capture position; update ignores that bit
		d = {1'b0, w};
		@(posedge tck) capture_dr <= 1'b1;
		@(posedge tck) capture_dr <= 1'b0;
		shift_dr <= 1'b1;
		for (int i = 0; i < 36; i++) begin
			tdi <= d[i];
			@(negedge tck) q[i] = tdo;
			@(posedge tck);
		end
		shift_dr <= 1'b0;
		// released data line shows the inverse, not a stale bit
		tdi <= ~d[35];
		update_dr <= 1'b1;
		@(posedge tck) update_dr <= 1'b0;
		repeat (4) @(posedge tck);
	endtask
endmodule
`default_nettype wire

// ===== tb/test_scan_adc_limit_check.sv
// bench for the scan-driven converter front end.
// assumes sadc_top and the tester model; pclk 8 ns, tck 160 ns.
`timescale 1ns/1ns
`default_nettype none

module test_scan_adc_limit_check;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic tck, tdi, capture_dr, shift_dr, update_dr, extest_active, tdo;
	logic comp_pin, x10_to_pin4, ref_supply_sel;
	sadc_pkg::sadc_ctrl_s adc_ctrl;
	logic [9:0] vin, held;
	logic [35:0] q;
	int err_count, check_count;

	sadc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tck(tck), .tdi(tdi),
		.capture_dr(capture_dr), .shift_dr(shift_dr),
		.update_dr(update_dr), .extest_active(extest_active),
		.tdo(tdo), .comp_pin(comp_pin), .adc_ctrl(adc_ctrl),
		.x10_to_pin4(x10_to_pin4), .ref_supply_sel(ref_supply_sel));
	sadc_tester u_tester (.tck(tck), .tdi(tdi), .capture_dr(capture_dr),
		.shift_dr(shift_dr), .update_dr(update_dr),
		.extest_active(extest_active), .tdo(tdo));

	// ==========================================================
	// analog stand-in: hold low tracks input, precharge low resolves
	always @(posedge pclk) begin
		if (adc_ctrl.hold === 1'b0)
			held <= vin;
		if (adc_ctrl.comparator_precharge_n === 1'b0)
			comp_pin <= adc_ctrl.dac_code > held;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk) begin
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
		end
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic sadc_pkg::sadc_ctrl_s mk(input logic [9:0] d,
		input logic h, input logic p);
		sadc_pkg::sadc_ctrl_s w;
		w = sadc_pkg::IDLE_WORD;
		w.converter_power_on = 1'b1;
		w.input_mux_select = 8'h08;
		w.dac_code = d;
		w.hold = h;
		w.comparator_precharge_n = p;
		return w;
	endfunction

	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk(adc_ctrl, sadc_pkg::IDLE_WORD);
		chk({x10_to_pin4, ref_supply_sel}, 2'b00);
		apb(12'h00C, 1'b0, 32'h0);
		chk({pready, err, rd}, {2'b11, 32'h0});
	endtask

	task automatic t_dummy();
		int n;
		n = 0;
		apb(sadc_pkg::OFF_CTRL, 1'b1, 32'h1);
		repeat (70) begin
			@(posedge pclk);
			if (adc_ctrl.comparator_precharge_n === 1'b0)
				n++;
		end
		chk(n, 10);
		chk(adc_ctrl.converter_power_on, 1'b1);
		apb(sadc_pkg::OFF_STATUS, 1'b0, 32'h0);
		chk(rd[1], 1'b1);
	endtask

	// normal conversion on channel 3 after the dummy one
	task automatic t_convert();
		apb(sadc_pkg::OFF_CTRL, 1'b1, 32'h0000_0033);
		repeat (80) @(posedge pclk);
		chk(adc_ctrl.input_mux_select, 8'h08);
		apb(sadc_pkg::OFF_CTRL, 1'b0, 32'h0);
		chk(rd, 32'h0000_0031);
		apb(sadc_pkg::OFF_STATUS, 1'b0, 32'h0);
		chk(rd[2:0], 3'b010);
		apb(sadc_pkg::OFF_RESULT, 1'b0, 32'h0);
		chk(rd, {22'h0, vin});
	endtask

	task automatic step(input logic [9:0] lim, output logic c);
		u_tester.frame(mk(10'h200, 1'b0, 1'b1), q);
		chk(adc_ctrl.hold, 1'b0);
		u_tester.frame(mk(10'h200, 1'b1, 1'b1), q);
		u_tester.frame(mk(lim, 1'b1, 1'b1), q);
		u_tester.frame(mk(lim, 1'b1, 1'b0), q);
		chk(adc_ctrl.comparator_precharge_n, 1'b0);
		u_tester.frame(mk(10'h200, 1'b1, 1'b1), q);
		c = q[35];
	endtask

	task automatic t_window(input logic [9:0] v, input logic exp);
		logic c_lo, c_hi;
		vin <= v;
		u_tester.frame(mk(10'h200, 1'b1, 1'b1), q);
		u_tester.set_extest(1'b1);
		step(10'h123, c_lo);
		step(10'h143, c_hi);
		chk({c_lo, c_hi} === 2'b01, exp);
	endtask

	task automatic t_route();
		sadc_pkg::sadc_ctrl_s w;
		w = mk(10'h200, 1'b1, 1'b1);
		w.switchcap_test_enable = 1'b1;
		w.supply_reference_select = 1'b1;
		u_tester.frame(w, q);
		chk(adc_ctrl, w);
		apb(sadc_pkg::OFF_STATUS, 1'b0, 32'h0);
		chk(rd[2], 1'b1);
		chk({x10_to_pin4, ref_supply_sel}, 2'b11);
		u_tester.frame(sadc_pkg::IDLE_WORD, q);
		chk({x10_to_pin4, ref_supply_sel}, 2'b00);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// clock, reset, sequence and watchdog
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		#400000;
		err_count++;
		summarize();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		comp_pin = 1'b0;
		vin = 10'h133;
		held = 10'h000;
		err_count = 0;
		check_count = 0;
		repeat (12) @(posedge pclk);
		// the slow link clock needs two edges inside reset as well
		repeat (2) @(posedge tck);
		@(posedge pclk) presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_dummy();
		t_convert();
		repeat (30) @(posedge pclk);
		t_window(10'h133, 1'b1);
		t_window(10'h150, 1'b0);
		t_route();
		summarize();
	end
endmodule
`default_nettype wire
